// file: design/qenc_pkg.sv
// Shared constants of the quadrature encoder output logic
package qenc_pkg;

   // System clock rate
   localparam int CLOCK_FREQ_KHZ = 250000;

   // Quadrature signal frequency limits per medium
   localparam int COPPER_MAX_FREQ_KHZ = 200;
   localparam int FIBRE_MAX_FREQ_KHZ = 100;

   // Least spacing of channel edges: four edges per period, rounded up
   localparam int COPPER_EDGE_GAP_CYCLES =
      (CLOCK_FREQ_KHZ + 4 * COPPER_MAX_FREQ_KHZ - 1) / (4 * COPPER_MAX_FREQ_KHZ);
   localparam int FIBRE_EDGE_GAP_CYCLES =
      (CLOCK_FREQ_KHZ + 4 * FIBRE_MAX_FREQ_KHZ - 1) / (4 * FIBRE_MAX_FREQ_KHZ);
   localparam int GAP_WIDTH = 10;

   // Standstill timeout and speed measuring window, in microseconds
   localparam int STANDSTILL_TIME_US = 100000;
   localparam int SPEED_WINDOW_US = 1000;
   localparam int CLOCK_FREQ_MHZ = CLOCK_FREQ_KHZ / 1000;

   // Shaft geometry: pulses per revolution and quarter steps per revolution
   localparam int PULSES_PER_REV = 1024;
   localparam int POS_WIDTH = 12;
   localparam logic [POS_WIDTH-1:0] POS_LAST = POS_WIDTH'(4 * PULSES_PER_REV - 1);
   localparam logic [POS_WIDTH-1:0] POS_ZERO = 12'h000;
   // Reference pulse lasts one full channel period at position zero
   localparam logic [POS_WIDTH-1:0] REF_STEPS = 12'h004;

   // Quadrature phase encoding, clockwise order counts upward
   localparam logic [1:0] PHASE_RESET = 2'h0;
   localparam logic [1:0] PHASE_STEP = 2'h1;

   // Edge backlog limits of the pacer
   localparam logic signed [4:0] BACKLOG_MAX = 5'sh07;
   localparam logic signed [4:0] BACKLOG_ONE = 5'sh01;

   // Overspeed edge counter width
   localparam int SPEED_WIDTH = 16;
   localparam logic [SPEED_WIDTH-1:0] SPEED_MAX = 16'hffff;

endpackage

// file: design/qenc_interval_timer.sv
`timescale 1ns/1ps
// Counts up to COUNT after a restart, then holds with expired high
module qenc_interval_timer #(
   parameter int COUNT = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic restart,
   output logic expired
);
   localparam int W = $clog2(COUNT + 1);
   localparam logic [W-1:0] LAST = W'(COUNT);

   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;

   // Next count, saturating at the terminal value
   always_comb begin
      count_next = count_reg;
      if (restart) begin
         count_next = '0;
      end else if (count_reg != LAST) begin
         count_next = count_reg + 1'b1;
      end
   end

   // Count register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   assign expired = (count_reg == LAST);
endmodule

// file: design/qenc_edge_pacer.sv
`timescale 1ns/1ps
// Holds a signed backlog of sensed steps and releases them spaced apart
module qenc_edge_pacer
   import qenc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic step_valid,
   input wire logic step_cw,
   input wire logic [GAP_WIDTH-1:0] min_gap,
   output logic edge_fire,
   output logic edge_cw,
   output logic overflow
);
   logic signed [4:0] backlog_reg;
   logic signed [4:0] backlog_next;
   logic [GAP_WIDTH-1:0] gap_reg;
   logic [GAP_WIDTH-1:0] gap_next;
   logic signed [4:0] step_in;
   logic signed [4:0] step_out;
   logic signed [4:0] sum;

   // Opposite steps cancel; a full backlog drops the step and reports it
   always_comb begin
      step_in = '0;
      step_out = '0;
      edge_fire = (backlog_reg != '0) && (gap_reg == '0);
      edge_cw = (backlog_reg > 5'sh00); // Signed compare, negative is counterclockwise
      if (step_valid) begin
         step_in = step_cw ? BACKLOG_ONE : -BACKLOG_ONE;
      end
      if (edge_fire) begin
         step_out = edge_cw ? BACKLOG_ONE : -BACKLOG_ONE;
      end
      sum = backlog_reg + step_in - step_out;
      overflow = 1'b0;
      backlog_next = sum;
      if (sum > BACKLOG_MAX || sum < -BACKLOG_MAX) begin
         overflow = 1'b1;
         backlog_next = backlog_reg - step_out;
      end
      gap_next = gap_reg;
      if (edge_fire) begin
         gap_next = min_gap - 1'b1;
      end else if (gap_reg != '0) begin
         gap_next = gap_reg - 1'b1;
      end
   end

   // Backlog and spacing registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         backlog_reg <= '0;
         gap_reg <= '0;
      end else begin
         backlog_reg <= backlog_next;
         gap_reg <= gap_next;
      end
   end
endmodule

// file: design/qenc_output_logic.sv
`timescale 1ns/1ps
// How it works
// - channel B lags channel A by 90 degrees when turning clockwise
// - every output has an inverted companion line
// - clockwise steps make channel A lead
// - one reference pulse per revolution at zero
// - self check drives fault, both polarities
// - doubled output carries twice the base pulses
// - direction output updated at every channel edge
// - extended option also flags shaft standstill
// - up/down option steers pulses per direction
// - overspeed switch with two independent thresholds
// - fibre link limits signal to 100 kHz
// - copper signal limited to 200 kHz
module qenc_output_logic
   import qenc_pkg::*;
#(
   parameter int STANDSTILL_CYCLES = STANDSTILL_TIME_US * CLOCK_FREQ_MHZ,
   parameter int SPEED_WINDOW_CYCLES = SPEED_WINDOW_US * CLOCK_FREQ_MHZ
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic step_valid,
   input wire logic step_cw,
   input wire logic sensor_fault,
   input wire logic fault_clear,
   input wire logic reference_option,
   input wire logic rate_doubling_option,
   input wire logic direction_option,
   input wire logic direction_standstill_option,
   input wire logic up_down_steering_option,
   input wire logic overspeed_option,
   input wire logic fibre_option,
   input wire logic [SPEED_WIDTH-1:0] speed_threshold_1,
   input wire logic [SPEED_WIDTH-1:0] speed_threshold_2,
   output logic chan_a,
   output logic chan_a_n,
   output logic chan_b,
   output logic chan_b_n,
   output logic ref_pulse,
   output logic ref_pulse_n,
   output logic fault,
   output logic fault_n,
   output logic doubled_rate,
   output logic doubled_rate_n,
   output logic direction_cw,
   output logic direction_cw_n,
   output logic standstill,
   output logic standstill_n,
   output logic clockwise_pulse_output,
   output logic clockwise_pulse_output_n,
   output logic counterclockwise_pulse_output,
   output logic counterclockwise_pulse_output_n,
   output logic overspeed_1,
   output logic overspeed_1_n,
   output logic overspeed_2,
   output logic overspeed_2_n
);
   localparam logic [GAP_WIDTH-1:0] COPPER_GAP = GAP_WIDTH'(COPPER_EDGE_GAP_CYCLES);
   localparam logic [GAP_WIDTH-1:0] FIBRE_GAP = GAP_WIDTH'(FIBRE_EDGE_GAP_CYCLES);
   // Quadrature phase codes in clockwise order after the reset code
   localparam logic [1:0] PHASE_A_ONLY = 2'h1;
   localparam logic [1:0] PHASE_BOTH = 2'h2;
   localparam logic [1:0] PHASE_B_ONLY = 2'h3;

   logic [GAP_WIDTH-1:0] min_gap;
   logic edge_fire;
   logic edge_cw;
   logic overflow;
   logic idle_expired;
   logic window_end;

   logic [1:0] phase_reg;
   logic [1:0] phase_next;
   logic [POS_WIDTH-1:0] pos_reg;
   logic [POS_WIDTH-1:0] pos_next;
   logic a_reg;
   logic a_next;
   logic b_reg;
   logic b_next;
   logic ref_reg;
   logic ref_next;
   logic dir_reg;
   logic dir_next;
   logic dir_out_reg;
   logic dir_out_next;
   logic still_reg;
   logic still_next;
   logic dbl_reg;
   logic dbl_next;
   logic cw_out_reg;
   logic cw_out_next;
   logic ccw_out_reg;
   logic ccw_out_next;
   logic fault_reg;
   logic fault_next;
   logic [SPEED_WIDTH-1:0] speed_cnt_reg;
   logic [SPEED_WIDTH-1:0] speed_cnt_next;
   logic over1_reg;
   logic over1_next;
   logic over2_reg;
   logic over2_next;

   // Edge spacing depends on the transmission medium
   assign min_gap = fibre_option ? FIBRE_GAP : COPPER_GAP;

   qenc_edge_pacer u_pacer (
      .clock(clock),
      .rst_n(rst_n),
      .step_valid(step_valid),
      .step_cw(step_cw),
      .min_gap(min_gap),
      .edge_fire(edge_fire),
      .edge_cw(edge_cw),
      .overflow(overflow)
   );

   // Standstill timeout, restarted by every channel edge
   qenc_interval_timer #(
      .COUNT(STANDSTILL_CYCLES)
   ) u_idle_timer (
      .clock(clock),
      .rst_n(rst_n),
      .restart(edge_fire),
      .expired(idle_expired)
   );

   // Periodic speed measuring window
   qenc_interval_timer #(
      .COUNT(SPEED_WINDOW_CYCLES - 1)
   ) u_window_timer (
      .clock(clock),
      .rst_n(rst_n),
      .restart(window_end),
      .expired(window_end)
   );

   // Quadrature phase and shaft position
   always_comb begin
      phase_next = phase_reg;
      pos_next = pos_reg;
      if (edge_fire) begin
         if (edge_cw) begin
            phase_next = phase_reg + PHASE_STEP;
            pos_next = (pos_reg == POS_LAST) ? POS_ZERO : pos_reg + 1'b1;
         end else begin
            phase_next = phase_reg - PHASE_STEP;
            pos_next = (pos_reg == POS_ZERO) ? POS_LAST : pos_reg - 1'b1;
         end
      end
      // Gray sequence 00, 10, 11, 01 on A, B puts B a quarter behind A
      a_next = 1'b0;
      b_next = 1'b0;
      unique case (phase_next)
         PHASE_RESET: begin
            a_next = 1'b0;
            b_next = 1'b0;
         end
         PHASE_A_ONLY: begin
            a_next = 1'b1;
            b_next = 1'b0;
         end
         PHASE_BOTH: begin
            a_next = 1'b1;
            b_next = 1'b1;
         end
         PHASE_B_ONLY: begin
            a_next = 1'b0;
            b_next = 1'b1;
         end
      endcase
      ref_next = reference_option && (pos_next < REF_STEPS);
      dbl_next = rate_doubling_option && (a_next ^ b_next);
   end

   // Direction from the phase transition, standstill from the idle timer
   always_comb begin
      dir_next = dir_reg;
      if (edge_fire) begin
         dir_next = (phase_next == phase_reg + PHASE_STEP);
      end
      dir_out_next = (direction_option || direction_standstill_option) && dir_next;
      still_next = direction_standstill_option && idle_expired;
   end

   // Up/down steering of channel A pulses
   always_comb begin
      cw_out_next = up_down_steering_option && dir_next && a_next;
      ccw_out_next = up_down_steering_option && !dir_next && a_next;
   end

   // Sticky fault; a new fault wins over a clear in the same cycle
   always_comb begin
      fault_next = fault_reg;
      if (fault_clear) begin
         fault_next = 1'b0;
      end
      if (sensor_fault || overflow) begin
         fault_next = 1'b1;
      end
   end

   // Edges counted per window and compared with both thresholds
   always_comb begin
      speed_cnt_next = speed_cnt_reg;
      over1_next = over1_reg;
      over2_next = over2_reg;
      if (window_end) begin
         over1_next = overspeed_option && (speed_cnt_reg > speed_threshold_1);
         over2_next = overspeed_option && (speed_cnt_reg > speed_threshold_2);
         speed_cnt_next = SPEED_WIDTH'(edge_fire);
      end else if (edge_fire && speed_cnt_reg != SPEED_MAX) begin
         speed_cnt_next = speed_cnt_reg + 1'b1;
      end
   end

   // Signal path registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= PHASE_RESET;
         pos_reg <= POS_ZERO;
         a_reg <= 1'b0;
         b_reg <= 1'b0;
         ref_reg <= 1'b0;
         dbl_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         pos_reg <= pos_next;
         a_reg <= a_next;
         b_reg <= b_next;
         ref_reg <= ref_next;
         dbl_reg <= dbl_next;
      end
   end

   // Direction and standstill registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dir_reg <= 1'b1;
         dir_out_reg <= 1'b0;
         still_reg <= 1'b0;
      end else begin
         dir_reg <= dir_next;
         dir_out_reg <= dir_out_next;
         still_reg <= still_next;
      end
   end

   // Steering registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cw_out_reg <= 1'b0;
         ccw_out_reg <= 1'b0;
      end else begin
         cw_out_reg <= cw_out_next;
         ccw_out_reg <= ccw_out_next;
      end
   end

   // Fault register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fault_reg <= 1'b0;
      end else begin
         fault_reg <= fault_next;
      end
   end

   // Overspeed registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         speed_cnt_reg <= '0;
         over1_reg <= 1'b0;
         over2_reg <= 1'b0;
      end else begin
         speed_cnt_reg <= speed_cnt_next;
         over1_reg <= over1_next;
         over2_reg <= over2_next;
      end
   end

   // True outputs straight from registers
   assign chan_a = a_reg;
   assign chan_b = b_reg;
   assign ref_pulse = ref_reg;
   assign fault = fault_reg;
   assign doubled_rate = dbl_reg;
   assign direction_cw = dir_out_reg;
   assign standstill = still_reg;
   assign clockwise_pulse_output = cw_out_reg;
   assign counterclockwise_pulse_output = ccw_out_reg;
   assign overspeed_1 = over1_reg;
   assign overspeed_2 = over2_reg;

   // Inverted companion lines
   assign chan_a_n = ~a_reg;
   assign chan_b_n = ~b_reg;
   assign ref_pulse_n = ~ref_reg;
   assign fault_n = ~fault_reg;
   assign doubled_rate_n = ~dbl_reg;
   assign direction_cw_n = ~dir_out_reg;
   assign standstill_n = ~still_reg;
   assign clockwise_pulse_output_n = ~cw_out_reg;
   assign counterclockwise_pulse_output_n = ~ccw_out_reg;
   assign overspeed_1_n = ~over1_reg;
   assign overspeed_2_n = ~over2_reg;
endmodule

// file: dv/qenc_properties.sv
`timescale 1ns/1ps
// Port checker of the encoder output logic
module qenc_properties
   import qenc_pkg::*;
#(
   parameter int STANDSTILL_CYCLES = 2000,
   parameter int SPEED_WINDOW_CYCLES = 5000
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sensor_fault,
   input wire logic reference_option,
   input wire logic rate_doubling_option,
   input wire logic direction_option,
   input wire logic up_down_steering_option,
   input wire logic fibre_option,
   input wire logic chan_a,
   input wire logic chan_a_n,
   input wire logic chan_b,
   input wire logic ref_pulse,
   input wire logic fault,
   input wire logic fault_n,
   input wire logic doubled_rate,
   input wire logic direction_cw,
   input wire logic standstill,
   input wire logic counterclockwise_pulse_output
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [1:0] ab_reg;
   logic [1:0] ab_next;
   logic [GAP_WIDTH-1:0] gap_reg;
   logic [GAP_WIDTH-1:0] gap_next;
   logic moved;
   // Cycles since the last channel edge, saturating
   always_comb begin
      moved = {chan_a, chan_b} != ab_reg;
      ab_next = {chan_a, chan_b};
      gap_next = moved ? '0 : ((gap_reg == '1) ? gap_reg : gap_reg + 1'b1);
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ab_reg <= 2'h0;
         gap_reg <= '1;
      end else begin
         ab_reg <= ab_next;
         gap_reg <= gap_next;
      end
   end
   line_pair_a: assert property (chan_a_n == !chan_a)
      else $error("chan_a_n is not the inverse");
   fault_pair_a: assert property (fault_n == !fault)
      else $error("fault_n is not the inverse");
   fault_set_a: assert property (sensor_fault |=> fault && !fault_n)
      else $error("fault not raised");
   one_chan_a: assert property (!($changed(chan_a) && $changed(chan_b)))
      else $error("both channels moved together");
   dbl_xor_a: assert property (
      rate_doubling_option |-> doubled_rate == (chan_a ^ chan_b))
      else $error("doubled output wrong");
   cw_lead_a: assert property (
      $rose(chan_a) && !chan_b && direction_option |-> direction_cw)
      else $error("clockwise edge not flagged");
   ccw_lag_a: assert property (
      $rose(chan_a) && chan_b && direction_option |-> !direction_cw)
      else $error("counterclockwise edge not flagged");
   steer_idle_a: assert property (
      up_down_steering_option && direction_option && direction_cw
      |-> !counterclockwise_pulse_output)
      else $error("idle steering output active");
   edge_gap_a: assert property (moved |-> gap_reg >= (fibre_option ?
      10'(FIBRE_EDGE_GAP_CYCLES - 1) : 10'(COPPER_EDGE_GAP_CYCLES - 1)))
      else $error("channel edges too close");
   still_clear_a: assert property (moved |=> !standstill)
      else $error("standstill while moving");
   ref_off_a: assert property (!reference_option |-> !ref_pulse)
      else $error("reference without option");
   // Main scenarios
   cover property ($rose(fault));
   cover property ($rose(standstill));
   cover property ($rose(counterclockwise_pulse_output));
endmodule
bind qenc_output_logic qenc_properties #(
   .STANDSTILL_CYCLES(STANDSTILL_CYCLES),
   .SPEED_WINDOW_CYCLES(SPEED_WINDOW_CYCLES)
) u_props (.clock(clock), .rst_n(rst_n), .sensor_fault(sensor_fault),
   .reference_option(reference_option), .rate_doubling_option(rate_doubling_option),
   .direction_option(direction_option), .up_down_steering_option(up_down_steering_option),
   .fibre_option(fibre_option), .chan_a(chan_a), .chan_a_n(chan_a_n), .chan_b(chan_b),
   .ref_pulse(ref_pulse), .fault(fault), .fault_n(fault_n), .doubled_rate(doubled_rate),
   .direction_cw(direction_cw), .standstill(standstill),
   .counterclockwise_pulse_output(counterclockwise_pulse_output));

// file: dv/qenc_counter_card.sv
`timescale 1ns/1ps
// Counter card: quadrature counter plus separate up and down counters
module qenc_counter_card (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic chan_a,
   input wire logic chan_b,
   input wire logic up_in,
   input wire logic down_in,
   output int quad_count,
   output int up_count,
   output int down_count
);
   logic [1:0] ab_reg;
   logic up_reg;
   logic down_reg;
   // Sampled every clock, so edges at the full copper rate are caught
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ab_reg = 2'h0;
         up_reg = 1'b0;
         down_reg = 1'b0;
         quad_count = 0;
         up_count = 0;
         down_count = 0;
      end else begin
         if ({chan_a, chan_b} == {~ab_reg[0], ab_reg[1]}) quad_count++;
         if ({chan_a, chan_b} == {ab_reg[0], ~ab_reg[1]}) quad_count--;
         if (up_in && !up_reg) up_count++;
         if (down_in && !down_reg) down_count++;
         ab_reg = {chan_a, chan_b};
         up_reg = up_in;
         down_reg = down_in;
      end
   end
endmodule

// file: dv/qenc_output_logic_bench.sv
`timescale 1ns/1ps
// Compare one result, count it, report a mismatch
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin err_count++; \
   $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
module qenc_output_logic_bench
   import qenc_pkg::*;
;
   localparam int STILL = 2000;
   logic clock = 0;
   logic rst_n = 0;
   logic step_valid = 0;
   logic step_cw = 0;
   logic sensor_fault = 0;
   logic fault_clear = 0;
   logic opt = 1;
   logic fibre_option = 0;
   logic [SPEED_WIDTH-1:0] thr1 = 16'h0003;
   logic [SPEED_WIDTH-1:0] thr2 = 16'h0010;
   logic chan_a, chan_a_n, chan_b, chan_b_n, ref_pulse, fault, fault_n, doubled_rate;
   logic direction_cw, standstill, cw_out, ccw_out;
   logic ref_pulse_n, doubled_rate_n, direction_cw_n, standstill_n, cw_out_n, ccw_out_n;
   logic overspeed_1, overspeed_1_n, overspeed_2, overspeed_2_n;
   logic [7:0] pos_lines, neg_lines;
   int quad_count, up_count, down_count, err_count, samples_checked;
   int pos, net, ups, downs;
   bit dir, uo, dno, c;
   logic [31:0] rnd = 32'h6814_f357;
   always #2 clock = ~clock;
   qenc_output_logic #(.STANDSTILL_CYCLES(STILL), .SPEED_WINDOW_CYCLES(5000)) DUT (
      .clock(clock), .rst_n(rst_n), .step_valid(step_valid), .step_cw(step_cw),
      .sensor_fault(sensor_fault), .fault_clear(fault_clear), .reference_option(opt),
      .rate_doubling_option(opt), .direction_option(opt), .direction_standstill_option(opt),
      .up_down_steering_option(opt), .overspeed_option(opt), .fibre_option(fibre_option),
      .speed_threshold_1(thr1), .speed_threshold_2(thr2), .chan_a(chan_a),
      .chan_a_n(chan_a_n), .chan_b(chan_b), .chan_b_n(chan_b_n), .ref_pulse(ref_pulse),
      .ref_pulse_n(ref_pulse_n), .fault(fault), .fault_n(fault_n),
      .doubled_rate(doubled_rate), .doubled_rate_n(doubled_rate_n),
      .direction_cw(direction_cw), .direction_cw_n(direction_cw_n),
      .standstill(standstill), .standstill_n(standstill_n), .clockwise_pulse_output(cw_out),
      .clockwise_pulse_output_n(cw_out_n), .counterclockwise_pulse_output(ccw_out),
      .counterclockwise_pulse_output_n(ccw_out_n), .overspeed_1(overspeed_1),
      .overspeed_1_n(overspeed_1_n), .overspeed_2(overspeed_2), .overspeed_2_n(overspeed_2_n));
   // True and companion lines side by side
   assign pos_lines = {ref_pulse, doubled_rate, direction_cw, standstill, cw_out, ccw_out,
      overspeed_1, overspeed_2};
   assign neg_lines = {ref_pulse_n, doubled_rate_n, direction_cw_n, standstill_n, cw_out_n,
      ccw_out_n, overspeed_1_n, overspeed_2_n};
   qenc_counter_card card (.clock(clock), .rst_n(rst_n), .chan_a(chan_a), .chan_b(chan_b),
      .up_in(cw_out), .down_in(ccw_out), .quad_count(quad_count), .up_count(up_count),
      .down_count(down_count));
   // Model of channel A from the shaft position
   function automatic bit ea();
      return (pos % 4) inside {1, 2};
   endfunction
   // Model of channel B from the shaft position
   function automatic bit eb();
      return (pos % 4) inside {2, 3};
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Advance the model by one quarter step
   task automatic apply(input bit cw);
      pos = (pos + (cw ? 1 : 4095)) % 4096;
      net += cw ? 1 : -1;
      dir = cw;
      if (ea() && cw && !uo) ups++;
      if (ea() && !cw && !dno) downs++;
      uo = ea() && cw;
      dno = ea() && !cw;
   endtask
   task automatic send(input bit cw);
      @(posedge clock);
      #1;
      step_valid = 1;
      step_cw = cw;
   endtask
   task automatic stop();
      @(posedge clock);
      #1;
      step_valid = 0;
   endtask
   task automatic wait_move();
      logic [1:0] was;
      was = {chan_a, chan_b};
      for (int i = 0; i < 1000; i++) begin
         @(posedge clock);
         #1;
         if ({chan_a, chan_b} !== was) begin
            // Counter card takes the new levels one edge later
            @(posedge clock);
            #1;
            return;
         end
      end
      err_count++;
      print_verdict();
   endtask
   task automatic check_all();
      `CHK("chan_a", ea(), chan_a)
      `CHK("chan_b", eb(), chan_b)
      `CHK("chan_b_n", !chan_b, chan_b_n)
      `CHK("inverse", ~pos_lines, neg_lines)
      `CHK("doubled", ea() ^ eb(), doubled_rate)
      `CHK("direction", dir, direction_cw)
      `CHK("cw_out", ea() && dir, cw_out)
      `CHK("ccw_out", ea() && !dir, ccw_out)
      `CHK("ref", pos < 4, ref_pulse)
      `CHK("standstill", 1'b0, standstill)
      `CHK("quad", net, quad_count)
      `CHK("ups", ups, up_count)
      `CHK("downs", downs, down_count)
   endtask
   // Threshold 1 at zero trips after motion and drops after an idle window
   task automatic watch_speed();
      bit seen_hi;
      bit seen_two;
      seen_hi = 0;
      seen_two = 0;
      for (int i = 0; i < 12000; i++) begin
         @(posedge clock);
         #1;
         seen_two |= overspeed_2;
         if (overspeed_1) seen_hi = 1;
         else if (seen_hi) break;
      end
      `CHK("over1_seen", 1'b1, seen_hi)
      `CHK("over1_low", 1'b0, overspeed_1)
      `CHK("over2", 1'b0, seen_two)
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      dir = 1;
      repeat (6) @(posedge clock);
      #1;
      rst_n = 1;
      opt = 0;
      @(posedge clock);
      #1;
      `CHK("ref_off", 1'b0, ref_pulse)
      `CHK("dir_off", 1'b0, direction_cw)
      opt = 1;
      repeat (STILL + 10) @(posedge clock);
      #1;
      `CHK("still", 1'b1, standstill)
      `CHK("ref_on", 1'b1, ref_pulse)
      for (int k = 0; k < 40; k++) begin
         rnd = xs(rnd);
         thr1 = rnd[31:16];
         fibre_option = k >= 30;
         // Let the copper spacing run out before the fibre spacing applies
         if (k == 30) repeat (FIBRE_EDGE_GAP_CYCLES) @(posedge clock);
         c = rnd[0];
         send(c);
         stop();
         apply(c);
         wait_move();
         check_all();
      end
      fibre_option = 0;
      thr1 = 16'h0000;
      for (int k = 0; k < 9; k++) send(1'b1);
      stop();
      // Backlog holds seven; the last two steps are dropped
      for (int k = 0; k < 7; k++) begin
         apply(1'b1);
         wait_move();
      end
      check_all();
      `CHK("overflow", 1'b1, fault)
      watch_speed();
      fault_clear = 1;
      @(posedge clock);
      #1;
      fault_clear = 0;
      `CHK("cleared", 1'b0, fault)
      sensor_fault = 1;
      @(posedge clock);
      #1;
      sensor_fault = 0;
      `CHK("fault", 1'b1, fault)
      `CHK("fault_n", 1'b0, fault_n)
      print_verdict();
   end
endmodule
